/* File: hw/rbs_consts.svh */
`ifndef RBS_CONSTS_SVH
`define RBS_CONSTS_SVH
// Functional notes
// - hold reset while the power-on detector reports supply below minimum.
// - power-up delay timer gives 64 ms, started by power-on or undervoltage reset.
// - keep reset asserted while the power-up delay timer counts.
// - delay timer enabled when its active-low config bit is clear, else bypassed.
// - delay timer starts only after power-on and undervoltage resets release.
// - undervoltage reset asserts reset when enabled detector reports low supply.
// - one config bit selects trip level, passed to the analog detector.
// - dips shorter than the filter time are ignored; longer ones reset.
// - mode 11 keeps protection on always, ignoring software enable and sleep.
// - always-on and off-in-sleep modes hold start-up until ready and supply good.
// - always-on mode protects in sleep; wake does not wait for ready.
// - mode 10 protects while the core is awake.
// - mode 10 disables the detector during sleep.
// - mode 10 holds wake-up until the re-enabled detector is ready.
// - mode 01 with enable clear, or mode 00: detector off, start immediately.
// - forced-on detector is ready before execution; start-up waits until it is ready.
// - mode 01 uses the software enable; start-up never waits on detector.
// - read-only ready flag reports detector ready; protection starts then.
// - in software mode, sleep does not change protection state.

// ****************************************
// timing
// ****************************************
`define RBS_CLK_MHZ          125
`define RBS_PWRUP_DELAY_MS   64
`define RBS_PWRUP_CYCLES     (`RBS_PWRUP_DELAY_MS * 1000 * `RBS_CLK_MHZ)
`define RBS_FILTER_TIME_NS   1000
`define RBS_FILTER_CYCLES    ((`RBS_FILTER_TIME_NS * `RBS_CLK_MHZ + 999) / 1000)

// ****************************************
// mode field encodings
// ****************************************
`define RBS_MODE_OFF         2'h0
`define RBS_MODE_SW          2'h1
`define RBS_MODE_NOSLEEP     2'h2
`define RBS_MODE_ON          2'h3
`endif

/* File: hw/rbs_pkg.sv */
package rbs_pkg;
  typedef enum logic [1:0] {
    RBS_ST_HOLD  = 2'b00,
    RBS_ST_DELAY = 2'b01,
    RBS_ST_WAIT  = 2'b10,
    RBS_ST_RUN   = 2'b11
  } rbs_state_t;
endpackage

/* File: hw/rbs_sequencer.sv */
`include "rbs_consts.svh"
`timescale 1ns/1ps
`default_nettype none
module rbs_sequencer
  import rbs_pkg::*;
#(
  parameter int PWRUP_CYCLES  = `RBS_PWRUP_CYCLES,
  parameter int FILTER_CYCLES = `RBS_FILTER_CYCLES
) (
  input  wire logic       core_clk,
  input  wire logic       resetn,
  input  wire logic       por_low_in,
  input  wire logic       uv_low_in,
  input  wire logic       uv_ready_in,
  input  wire logic       powerup_delay_enable_n,
  input  wire logic [1:0] undervoltage_mode_cfg,
  input  wire logic       undervoltage_level_cfg,
  input  wire logic       undervoltage_sw_enable,
  input  wire logic       core_sleep,
  output logic            undervoltage_level_sel,
  output logic            uv_detector_enable,
  output logic            undervoltage_ready_flag,
  output logic            undervoltage_reset,
  output logic            powerup_timer_running,
  output logic            core_reset,
  output logic            core_start
);
  // ****************************************
  // synchronisers
  // ****************************************
  rbs_sync_if sy ();

  rbs_sync3 #(.RST_VAL(1'b1)) u_sync_por (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (por_low_in),
    .dout     (sy.por_low)
  );

  rbs_sync3 #(.RST_VAL(1'b0)) u_sync_uv (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (uv_low_in),
    .dout     (sy.uv_low)
  );

  rbs_sync3 #(.RST_VAL(1'b0)) u_sync_rdy (
    .core_clk (core_clk),
    .resetn   (resetn),
    .din      (uv_ready_in),
    .dout     (sy.uv_rdy)
  );

  // ****************************************
  // mode decode
  // ****************************************
  logic det_en;
  logic forced_mode;
  logic sw_mode;

  assign sw_mode     = (undervoltage_mode_cfg == `RBS_MODE_SW);
  assign forced_mode = (undervoltage_mode_cfg == `RBS_MODE_ON) ||
                       (undervoltage_mode_cfg == `RBS_MODE_NOSLEEP);

  always_comb begin
    case (undervoltage_mode_cfg)
      `RBS_MODE_ON:      det_en = 1'b1;
      `RBS_MODE_NOSLEEP: det_en = !core_sleep;
      `RBS_MODE_SW:      det_en = undervoltage_sw_enable;
      default:           det_en = 1'b0;
    endcase
  end

  // ****************************************
  // detector control outputs
  // ****************************************
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      undervoltage_level_sel  <= 1'b0;
      uv_detector_enable      <= 1'b0;
      undervoltage_ready_flag <= 1'b0;
    end else begin
      undervoltage_level_sel  <= undervoltage_level_cfg;
      uv_detector_enable      <= det_en;
      undervoltage_ready_flag <= det_en && sy.uv_rdy;
    end
  end

  // ****************************************
  // noise filter on undervoltage
  // ****************************************
  logic [15:0] filt_cnt_r;
  logic        uv_armed;

  // protection acts once the enabled detector is ready
  assign uv_armed = uv_detector_enable && undervoltage_ready_flag;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      filt_cnt_r <= 16'h0000;
    end else if (!(uv_armed && sy.uv_low)) begin
      filt_cnt_r <= 16'h0000;
    end else if (filt_cnt_r != 16'(FILTER_CYCLES)) begin
      filt_cnt_r <= filt_cnt_r + 16'h0001;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      undervoltage_reset <= 1'b0;
    end else if (!uv_armed || !sy.uv_low) begin
      undervoltage_reset <= 1'b0;
    end else if (filt_cnt_r == 16'(FILTER_CYCLES)) begin
      undervoltage_reset <= 1'b1;
    end
  end

  // ****************************************
  // power-up delay timer
  // ****************************************
  logic [31:0] powerup_delay_timer_cnt_r;
  logic        powerup_delay_timer_load;
  logic        src_reset;

  assign src_reset = sy.por_low || undervoltage_reset;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      powerup_delay_timer_load <= 1'b1;
    end else if (src_reset) begin
      powerup_delay_timer_load <= 1'b1;
    end else begin
      powerup_delay_timer_load <= 1'b0;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      powerup_delay_timer_cnt_r <= 32'h00000000;
    end else if (src_reset || powerup_delay_enable_n) begin
      powerup_delay_timer_cnt_r <= 32'h00000000;
    end else if (powerup_delay_timer_load) begin
      powerup_delay_timer_cnt_r <= 32'(PWRUP_CYCLES);
    end else if (powerup_delay_timer_cnt_r != 32'h00000000) begin
      powerup_delay_timer_cnt_r <= powerup_delay_timer_cnt_r - 32'h00000001;
    end
  end

  // counting or about to load keeps reset held
  assign powerup_timer_running = !powerup_delay_enable_n &&
                                 (powerup_delay_timer_load || (powerup_delay_timer_cnt_r != 32'h00000000));

  // ****************************************
  // sequencing state
  // ****************************************
  rbs_state_t state_r;
  rbs_state_t state_nxt;
  logic       wake_wait_r;
  logic       hold_any;

  assign hold_any = sy.por_low || undervoltage_reset || powerup_timer_running;

  // armed during sleep in mode 10, so the first awake cycle is already held
  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      wake_wait_r <= 1'b0;
    end else if (core_sleep &&
                 undervoltage_mode_cfg == `RBS_MODE_NOSLEEP) begin
      wake_wait_r <= 1'b1;
    end else if (undervoltage_ready_flag ||
                 undervoltage_mode_cfg != `RBS_MODE_NOSLEEP) begin
      wake_wait_r <= 1'b0;
    end
  end

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      RBS_ST_HOLD: begin
        if (!sy.por_low && !undervoltage_reset) begin
          state_nxt = RBS_ST_DELAY;
        end
      end
      RBS_ST_DELAY: begin
        if (sy.por_low || undervoltage_reset) begin
          state_nxt = RBS_ST_HOLD;
        end else if (!powerup_timer_running) begin
          state_nxt = RBS_ST_WAIT;
        end
      end
      RBS_ST_WAIT: begin
        if (hold_any) begin
          state_nxt = RBS_ST_HOLD;
        end else if (!forced_mode) begin
          state_nxt = RBS_ST_RUN;
        end else if (undervoltage_ready_flag && !sy.uv_low) begin
          state_nxt = RBS_ST_RUN;
        end
      end
      RBS_ST_RUN: begin
        if (hold_any) begin
          state_nxt = RBS_ST_HOLD;
        end
      end
      default: state_nxt = RBS_ST_HOLD;
    endcase
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      state_r <= RBS_ST_HOLD;
    end else begin
      state_r <= state_nxt;
    end
  end

  // ****************************************
  // outputs to the core
  // ****************************************
  assign core_reset = sy.por_low ||
                      undervoltage_reset ||
                      powerup_timer_running;

  assign core_start = (state_r == RBS_ST_RUN) && !core_reset &&
                      !wake_wait_r;
endmodule // rbs_sequencer
`default_nettype wire

/* File: hw/rbs_sync3.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// three-stage synchroniser, change on stage 2/3 agreement
// ****************************************
module rbs_sync3 #(
  parameter logic RST_VAL = 1'b0
) (
  input  wire logic core_clk,
  input  wire logic resetn,
  input  wire logic din,
  output var  logic dout
);
  logic s1_r;
  logic s2_r;
  logic s3_r;

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      s1_r <= RST_VAL;
      s2_r <= RST_VAL;
      s3_r <= RST_VAL;
    end else begin
      s1_r <= din;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  always_ff @(posedge core_clk) begin
    if (!resetn) begin
      dout <= RST_VAL;
    end else if (s2_r == s3_r) begin
      dout <= s3_r;
    end
  end
endmodule // rbs_sync3
`default_nettype wire

/* File: hw/rbs_sync_if.sv */
`timescale 1ns/1ps
`default_nettype none
// ****************************************
// synchronised detector levels
// ****************************************
interface rbs_sync_if;
  logic por_low;
  logic uv_low;
  logic uv_rdy;
  modport src (output por_low, output uv_low, output uv_rdy);
  modport dst (input por_low, input uv_low, input uv_rdy);
endinterface
`default_nettype wire

/* File: tb/rbs_detector_model.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// analog supply detectors
// ****
module rbs_detector_model (
  input  wire logic       core_clk,
  input  wire logic [1:0] supply,
  input  wire logic       level_sel,
  input  wire logic       det_en,
  output logic            por_low,
  output logic            uv_low,
  output logic            uv_ready
);
  int   rdy_cnt = 0;
  logic junk_r  = 1'b0;
  always_ff @(posedge core_clk) begin
    rdy_cnt <= det_en ? (rdy_cnt < 10 ? rdy_cnt + 1 : rdy_cnt) : 0;
    junk_r  <= !junk_r;
  end
  assign por_low  = supply == 2'h0;
  // a disabled detector gives garbage, not its last level
  assign uv_low   = det_en ? supply <= {1'b0, level_sel} + 2'h1 : junk_r;
  assign uv_ready = det_en && rdy_cnt == 10;
endmodule // rbs_detector_model
`default_nettype wire

/* File: tb/rbs_sequencer_sva.sv */
`timescale 1ns/1ps
`default_nettype none
// ****
// port checks of the reset sequencer
// ****
module rbs_sequencer_sva (
  input wire logic       core_clk,
  input wire logic       resetn,
  input wire logic       por_low_in,
  input wire logic       uv_low_in,
  input wire logic       powerup_delay_enable_n,
  input wire logic [1:0] undervoltage_mode_cfg,
  input wire logic       undervoltage_level_cfg,
  input wire logic       undervoltage_sw_enable,
  input wire logic       core_sleep,
  input wire logic       undervoltage_level_sel,
  input wire logic       uv_detector_enable,
  input wire logic       undervoltage_reset,
  input wire logic       powerup_timer_running,
  input wire logic       core_reset
);
  wire [1:0] m = undervoltage_mode_cfg;
  wire       sw = undervoltage_sw_enable;
  default clocking @(posedge core_clk); endclocking
  default disable iff (!resetn);
  property p_por; por_low_in [*6] |-> core_reset; endproperty
  a_por: assert property (p_por) else $error("por hold");
  property p_tmr; powerup_timer_running |-> core_reset; endproperty
  a_tmr: assert property (p_tmr) else $error("timer hold");
  property p_byp;
    powerup_delay_enable_n [*2] |-> !powerup_timer_running;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass");
  property p_uv; undervoltage_reset |-> core_reset; endproperty
  a_uv: assert property (p_uv) else $error("uv hold");
  property p_lvl;
    $past(resetn) |-> undervoltage_level_sel == $past(undervoltage_level_cfg);
  endproperty
  a_lvl: assert property (p_lvl) else $error("level");
  // pin must have been low-supply well inside the filter span
  property p_flt; $rose(undervoltage_reset) |-> $past(uv_low_in, 7); endproperty
  a_flt: assert property (p_flt) else $error("filter");
  property p_on; (resetn && m == 2'h3) [*3] |-> uv_detector_enable; endproperty
  a_on: assert property (p_on) else $error("mode on");
  property p_off;
    (resetn && (m == 2'h0 || m == 2'h1 && !sw)) [*3] |-> !uv_detector_enable;
  endproperty
  a_off: assert property (p_off) else $error("mode off");
  property p_slp;
    (resetn && m == 2'h2 && core_sleep) [*3] |-> !uv_detector_enable;
  endproperty
  a_slp: assert property (p_slp) else $error("sleep off");
endmodule // rbs_sequencer_sva
bind rbs_sequencer rbs_sequencer_sva i_rbs_sequencer_sva (.*);
`default_nettype wire

/* File: tb/reset_brownout_sequencer_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module reset_brownout_sequencer_bench;
  localparam int PW = 50;
  logic       core_clk, resetn, en_n, lvl, sw, slp;
  logic [1:0] mode, supply;
  logic       por, uvl, rdy, lsel, den, rflag, uvr, tmr, crst, cst;
  int         fails = 0;
  int         n_compared = 0;
  int         k;
  // {mode, sw enable, sleep, expected detector enable}
  logic [4:0] rows [8] = '{5'h19, 5'h1B, 5'h11, 5'h12, 5'h0D, 5'h0F, 5'h08,
                           5'h04};
  rbs_sequencer #(.PWRUP_CYCLES(PW), .FILTER_CYCLES(4)) i_rbs_sequencer (
    .core_clk(core_clk), .resetn(resetn), .por_low_in(por),
    .uv_low_in(uvl), .uv_ready_in(rdy), .powerup_delay_enable_n(en_n),
    .undervoltage_mode_cfg(mode), .undervoltage_level_cfg(lvl),
    .undervoltage_sw_enable(sw), .core_sleep(slp),
    .undervoltage_level_sel(lsel), .uv_detector_enable(den),
    .undervoltage_ready_flag(rflag), .undervoltage_reset(uvr),
    .powerup_timer_running(tmr), .core_reset(crst), .core_start(cst));
  rbs_detector_model i_rbs_detector_model (.core_clk(core_clk),
    .supply(supply), .level_sel(lsel), .det_en(den), .por_low(por),
    .uv_low(uvl), .uv_ready(rdy));
  task chk(input string nm, input logic e, input logic s);
    n_compared++;
    if (s !== e) begin
      fails++;
      $display("[ERR] %s exp %b got %b", nm, e, s);
    end
  endtask
  task cyc(input int n);
    repeat (n) @(posedge core_clk);
  endtask
  task wrap_up;
    $display("compared %0d failed %0d", n_compared, fails);
    if (fails == 0 && n_compared > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask
  initial begin
    core_clk = 1'b0;
    forever #4 core_clk = ~core_clk;
  end
  initial begin
    #100000;
    fails++;
    wrap_up();
  end
  initial begin
    {resetn, en_n, lvl, sw, slp, mode, supply} <= 9'h00C;
    cyc(8);
    #1 chk("rst", 1'b1, crst);
    cyc(8);
    resetn <= 1'b1;
    cyc(20);
    #1 chk("por", 1'b1, crst);
    cyc(1);
    supply <= 2'h3;
    for (k = 0; tmr !== 1'b0 && k < 200; k++) begin
      cyc(1);
      #1;
    end
    chk("powerup_delay_timer_len", 1'b1, k >= PW && k <= PW + 8);
    cyc(10);
    #1 chk("start", 1'b1, cst);
    for (int i = 0; i < 8; i++) begin
      cyc(1);
      {mode, sw, slp} <= rows[i][4:1];
      cyc(5);
      #1 chk("det_en", rows[i][0], den);
      chk("no_rst", 1'b0, crst);
    end
    cyc(1);
    {mode, slp} <= 3'h6;
    cyc(30);
    supply <= 2'h1;
    cyc(2);
    supply <= 2'h3;
    for (int i = 0; i < 15; i++) begin
      cyc(1);
      #1 chk("dip", 1'b0, uvr);
    end
    supply <= 2'h1;
    cyc(20);
    #1 chk("uv_rst", 1'b1, uvr);
    cyc(1);
    supply <= 2'h3;
    for (k = 0; uvr !== 1'b0 && k < 50; k++) begin
      cyc(1);
      #1;
    end
    cyc(PW - 10);
    #1 chk("uv_powerup_delay_timer", 1'b1, tmr & crst);
    cyc(30);
    supply <= 2'h2;
    cyc(20);
    #1 chk("lvl_lo", 1'b0, uvr);
    cyc(1);
    lvl <= 1'b1;
    cyc(20);
    #1 chk("lvl_hi", 1'b1, uvr & lsel);
    cyc(1);
    {en_n, supply} <= 3'h7;
    cyc(20);
    #1 chk("bypass", 1'b0, tmr | crst);
    cyc(1);
    {mode, slp} <= 3'h5;
    cyc(10);
    slp <= 1'b0;
    cyc(3);
    #1 chk("wake_wait", 1'b0, cst | crst);
    cyc(40);
    #1 chk("wake_go", 1'b1, cst);
    cyc(1);
    mode <= 2'h3;
    cyc(30);
    slp <= 1'b1;
    cyc(10);
    slp <= 1'b0;
    cyc(2);
    #1 chk("wake_on", 1'b1, cst);
    wrap_up();
  end
endmodule // reset_brownout_sequencer_bench
`default_nettype wire
